//--- inc/evh_params.svh
// Offsets, field positions, reset values and timing counts of the event input handler
`ifndef EVH_PARAMS_SVH
`define EVH_PARAMS_SVH

`define EVH_ADDR_W 8
`define EVH_OFS_ASSIGN 8'h00
`define EVH_OFS_OPTION 8'h04
`define EVH_OFS_COMMAND 8'h08
`define EVH_OFS_STATUS 8'h0c
`define EVH_ASSIGN_RST 32'h0000_0000
`define EVH_OPTION_RST 32'h0000_0000
`define EVH_FIELD_W 4
`define EVH_OPT_SERIAL 0
`define EVH_CMD_RESET 0
`define EVH_CMD_RUN 1
`define EVH_CMD_REMOTE 2
`define EVH_CMD_LOCAL 3
`define EVH_CMD_MANUAL 4
`define EVH_CMD_AUTO 5
`define EVH_CMD_HOLD 6
`define EVH_CMD_UNHOLD 7
`define EVH_CMD_ADVANCE 8
`define EVH_CMD_PATWR 9
`define EVH_CMD_PAT_LO 12
`define EVH_CMD_SERIAL 15
`define EVH_RESP_OKAY 2'h0
`define EVH_RESP_SLVERR 2'h2
`define EVH_FILTER_MS 200
`define EVH_CLK_HZ 20000000
`define EVH_FILTER_CYCLES (`EVH_FILTER_MS * (`EVH_CLK_HZ / 1000))

`endif

//--- inc/evh_pkg.sv
// Types shared by the event input handler
package evh_pkg;

    // Function an event input is assigned to; order gives the register encoding 0 to 8
    typedef enum logic [3:0] {
        EVH_FN_NONE,
        EVH_FN_RUNRST,
        EVH_FN_REMOTE,
        EVH_FN_MANUAL,
        EVH_FN_HOLD,
        EVH_FN_ADVANCE,
        EVH_FN_PAT0,
        EVH_FN_PAT1,
        EVH_FN_PAT2
    } evh_func_t;

    typedef enum logic {
        EVH_PRG_RESET,
        EVH_PRG_RUN
    } evh_prog_t;

endpackage

//--- src/evh_input_filter.sv
// Persistence filter for one event input
`timescale 1ns/1ps
`include "evh_params.svh"
module evh_input_filter #(
    parameter int unsigned FILTER_CYCLES = `EVH_FILTER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rawIn,
    output logic level
);
    localparam int unsigned CNT_W = $clog2(FILTER_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(FILTER_CYCLES - 1);

    logic [CNT_W-1:0] count_q;
    logic level_q;

    // Any return to the accepted level restarts the wait, so chatter never gets through
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (rawIn == level_q || count_q == LAST)
            count_q <= '0;
        else
            count_q <= count_q + CNT_W'(1);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            level_q <= 1'b0;
        else if (rawIn != level_q && count_q == LAST)
            level_q <= rawIn;
    end

    assign level = level_q;
endmodule

//--- src/evh_axil_port.sv
// AXI4-Lite slave handshakes; register decode stays with the caller
`timescale 1ns/1ps
`include "evh_params.svh"
module evh_axil_port #(
    parameter int unsigned ADDR_W = `EVH_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrEn,
    output logic [ADDR_W-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrErr,
    output logic [ADDR_W-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdErr
);
    logic awFull_q;
    logic wFull_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    assign s_axi_awready = !awFull_q;
    assign s_axi_wready = !wFull_q;
    assign s_axi_arready = !rvalid_q;
    assign wrEn = awFull_q && wFull_q && !bvalid_q;
    assign rdAddr = s_axi_araddr;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awFull_q <= 1'b0;
            wFull_q <= 1'b0;
            wrAddr <= '0;
            wrData <= '0;
            wrStrb <= '0;
        end
        else
        begin
            if (s_axi_awvalid && !awFull_q)
            begin
                awFull_q <= 1'b1;
                wrAddr <= s_axi_awaddr;
            end
            else if (wrEn)
                awFull_q <= 1'b0;
            if (s_axi_wvalid && !wFull_q)
            begin
                wFull_q <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
            else if (wrEn)
                wFull_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `EVH_RESP_OKAY;
        end
        else if (wrEn)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wrErr ? `EVH_RESP_SLVERR : `EVH_RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= `EVH_RESP_OKAY;
            rdata_q <= '0;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= rdErr ? `EVH_RESP_SLVERR : `EVH_RESP_OKAY;
            rdata_q <= rdData;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule

//--- src/evh_event_handler.sv
// Event input function handler: filters, assignment decode, program state and lamps
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "evh_params.svh"
module evh_event_handler #(
    parameter int unsigned FILTER_CYCLES = `EVH_FILTER_CYCLES,
    parameter int unsigned NUM_INPUTS = 4,
    parameter int unsigned STEP_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [NUM_INPUTS-1:0] eventIn,
    input wire logic [`EVH_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`EVH_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic programRun,
    output logic resetLamp,
    output logic remote_lamp,
    output logic hand_mode_lamp,
    output logic holdLamp,
    output logic stepPulse,
    output logic [2:0] patternNo,
    output logic keyWriteAllowed
);
    localparam int unsigned FW = `EVH_FIELD_W;
    localparam logic [31:0] OPTION_RST = `EVH_OPTION_RST;

    logic wrEn;
    logic [`EVH_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrErr;
    logic [`EVH_ADDR_W-1:0] rdAddr;
    logic [31:0] rdData;
    logic rdErr;

    logic [NUM_INPUTS-1:0] filt;
    logic [NUM_INPUTS-1:0] filtPrev_q;
    logic [NUM_INPUTS-1:0] rise;
    logic [NUM_INPUTS-1:0] fall;

    logic [NUM_INPUTS*FW-1:0] assign_q;
    logic [NUM_INPUTS*FW-1:0] assign_d;
    logic assignRefused_d;
    logic assignRefused_q;
    logic serialFitted_q;
    evh_pkg::evh_prog_t prog_q;
    logic remote_q;
    logic manual_q;
    logic hold_q;
    logic [2:0] pattern_q;
    logic [STEP_W-1:0] step_q;
    logic stepPulse_q;

    logic cmdValid;
    logic [15:0] cmd;
    logic running;
    logic runRise;
    logic runFall;
    logic advRise;
    logic [2:0] patSel;

    function automatic evh_pkg::evh_func_t funcOf(input logic [NUM_INPUTS*FW-1:0] asg, input int unsigned idx);
        funcOf = evh_pkg::evh_func_t'(asg[idx*FW +: FW]);
    endfunction

    // OR of the given per-input flags over the inputs holding one function
    function automatic logic anyOf(input logic [NUM_INPUTS*FW-1:0] asg, input logic [NUM_INPUTS-1:0] flags,
                                   input evh_pkg::evh_func_t fn);
        anyOf = 1'b0;
        for (int unsigned i = 0; i < NUM_INPUTS; i++)
            if (funcOf(asg, i) == fn && flags[i])
                anyOf = 1'b1;
    endfunction

    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        for (int unsigned b = 0; b < 4; b++)
            mergeStrb[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
    endfunction

    function automatic logic isAddr(input logic [`EVH_ADDR_W-1:0] a, input logic [`EVH_ADDR_W-1:0] ofs);
        isAddr = {a[`EVH_ADDR_W-1:2], 2'b00} == ofs;
    endfunction

    evh_axil_port #(
        .ADDR_W(`EVH_ADDR_W)
    ) u_port (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrErr(wrErr),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdErr(rdErr)
    );

    for (genvar g = 0; g < NUM_INPUTS; g++)
    begin : g_filt
        evh_input_filter #(
            .FILTER_CYCLES(FILTER_CYCLES)
        ) u_filt (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .rawIn(eventIn[g]),
            .level(filt[g])
        );
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            filtPrev_q <= '0;
        else
            filtPrev_q <= filt;
    end

    assign rise = filt & ~filtPrev_q;
    assign fall = ~filt & filtPrev_q;
    assign running = prog_q == evh_pkg::EVH_PRG_RUN;

    // Only commands from the serial side get through while remote is on
    assign cmdValid = wrEn && isAddr(wrAddr, `EVH_OFS_COMMAND)
                      && (!remote_q || wrData[`EVH_CMD_SERIAL]);
    assign cmd = cmdValid ? 16'(mergeStrb(32'h0000_0000, wrData, wrStrb)) : 16'h0000;

    assign runRise = anyOf(assign_q, rise, evh_pkg::EVH_FN_RUNRST);
    assign runFall = anyOf(assign_q, fall, evh_pkg::EVH_FN_RUNRST);
    assign advRise = anyOf(assign_q, rise, evh_pkg::EVH_FN_ADVANCE);
    // Unassigned select bits fall out of the OR as zero
    assign patSel = {anyOf(assign_q, filt, evh_pkg::EVH_FN_PAT2),
                     anyOf(assign_q, filt, evh_pkg::EVH_FN_PAT1),
                     anyOf(assign_q, filt, evh_pkg::EVH_FN_PAT0)};

    // Each field is checked on its own; a refused field keeps its old function
    always_comb
    begin
        logic [31:0] merged;
        merged = mergeStrb(32'(assign_q), wrData, wrStrb);
        assign_d = assign_q;
        assignRefused_d = 1'b0;
        for (int unsigned i = 0; i < NUM_INPUTS; i++)
        begin
            if (merged[i*FW +: FW] > FW'(evh_pkg::EVH_FN_PAT2))
                assignRefused_d = 1'b1;
            else if (merged[i*FW +: FW] == FW'(evh_pkg::EVH_FN_REMOTE) && i < 2)
                assignRefused_d = 1'b1;
            else if (merged[i*FW +: FW] == FW'(evh_pkg::EVH_FN_REMOTE) && !serialFitted_q)
                assignRefused_d = 1'b1;
            else
                assign_d[i*FW +: FW] = merged[i*FW +: FW];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            assign_q <= (NUM_INPUTS*FW)'(`EVH_ASSIGN_RST);
            assignRefused_q <= 1'b0;
        end
        else if (wrEn && isAddr(wrAddr, `EVH_OFS_ASSIGN))
        begin
            assign_q <= assign_d;
            assignRefused_q <= assignRefused_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            serialFitted_q <= OPTION_RST[`EVH_OPT_SERIAL];
        else if (wrEn && isAddr(wrAddr, `EVH_OFS_OPTION) && wrStrb[0])
            serialFitted_q <= wrData[`EVH_OPT_SERIAL];
    end

    // A coincident input edge and command: the input edge is applied, the command dropped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prog_q <= evh_pkg::EVH_PRG_RESET;
        else if (runRise)
            prog_q <= evh_pkg::EVH_PRG_RESET;
        else if (runFall)
            prog_q <= evh_pkg::EVH_PRG_RUN;
        else if (cmd[`EVH_CMD_RESET])
            prog_q <= evh_pkg::EVH_PRG_RESET;
        else if (cmd[`EVH_CMD_RUN])
            prog_q <= evh_pkg::EVH_PRG_RUN;
    end

    // Remote/local; losing the serial option drops back to local
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            remote_q <= 1'b0;
        else if (!serialFitted_q)
            remote_q <= 1'b0;
        else if (anyOf(assign_q, '1, evh_pkg::EVH_FN_REMOTE))
            remote_q <= anyOf(assign_q, filt, evh_pkg::EVH_FN_REMOTE);
        else if (cmd[`EVH_CMD_REMOTE])
            remote_q <= 1'b1;
        else if (cmd[`EVH_CMD_LOCAL])
            remote_q <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            manual_q <= 1'b0;
        else if (anyOf(assign_q, '1, evh_pkg::EVH_FN_MANUAL))
            manual_q <= anyOf(assign_q, filt, evh_pkg::EVH_FN_MANUAL);
        else if (cmd[`EVH_CMD_MANUAL])
            manual_q <= 1'b1;
        else if (cmd[`EVH_CMD_AUTO])
            manual_q <= 1'b0;
    end

    // Hold has no meaning outside a running program, so reset always clears it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hold_q <= 1'b0;
        else if (!running)
            hold_q <= 1'b0;
        else if (anyOf(assign_q, '1, evh_pkg::EVH_FN_HOLD))
            hold_q <= anyOf(assign_q, filt, evh_pkg::EVH_FN_HOLD);
        else if (cmd[`EVH_CMD_HOLD])
            hold_q <= 1'b1;
        else if (cmd[`EVH_CMD_UNHOLD])
            hold_q <= 1'b0;
    end

    // Step advance; advancing also releases nothing else, hold stays as it is
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_q <= '0;
            stepPulse_q <= 1'b0;
        end
        else if (!running)
        begin
            step_q <= '0;
            stepPulse_q <= 1'b0;
        end
        else if (advRise || cmd[`EVH_CMD_ADVANCE])
        begin
            step_q <= step_q + STEP_W'(1);
            stepPulse_q <= 1'b1;
        end
        else
            stepPulse_q <= 1'b0;
    end

    // While running the pattern is frozen; while reset it follows the inputs if any holds a pattern function, else the pattern command
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pattern_q <= 3'h0;
        else if (running)
            pattern_q <= pattern_q;
        else if (anyOf(assign_q, '1, evh_pkg::EVH_FN_PAT0) || anyOf(assign_q, '1, evh_pkg::EVH_FN_PAT1)
                 || anyOf(assign_q, '1, evh_pkg::EVH_FN_PAT2))
            pattern_q <= patSel;
        else if (cmd[`EVH_CMD_PATWR])
            pattern_q <= cmd[`EVH_CMD_PAT_LO +: 3];
    end

    always_comb
    begin
        rdData = 32'h0000_0000;
        rdErr = 1'b0;
        if (isAddr(rdAddr, `EVH_OFS_ASSIGN))
            rdData = 32'(assign_q);
        else if (isAddr(rdAddr, `EVH_OFS_OPTION))
            rdData[`EVH_OPT_SERIAL] = serialFitted_q;
        else if (isAddr(rdAddr, `EVH_OFS_STATUS))
        begin
            rdData[0] = running;
            rdData[1] = !running;
            rdData[2] = remote_q;
            rdData[3] = manual_q;
            rdData[4] = hold_q;
            rdData[10:8] = pattern_q;
            rdData[12 +: NUM_INPUTS] = filt;
            rdData[16 +: STEP_W] = step_q;
            rdData[24] = assignRefused_q;
        end
        else if (!isAddr(rdAddr, `EVH_OFS_COMMAND))
            rdErr = 1'b1;
    end

    assign wrErr = !(isAddr(wrAddr, `EVH_OFS_ASSIGN) || isAddr(wrAddr, `EVH_OFS_OPTION)
                     || isAddr(wrAddr, `EVH_OFS_COMMAND));

    assign programRun = running;
    assign resetLamp = !running;
    assign remote_lamp = remote_q;
    assign hand_mode_lamp = manual_q;
    assign holdLamp = hold_q;
    assign stepPulse = stepPulse_q;
    assign patternNo = pattern_q;
    assign keyWriteAllowed = !remote_q;
endmodule

//--- tb/evh_contacts.sv
// External contact model driving the event inputs
`timescale 1ns/1ps
module evh_contacts (
    input wire logic clk_sys,
    input wire logic [3:0] wantIn,
    output logic [3:0] eventIn
);
    initial eventIn = 4'h0;
    // Contacts move just after an edge and rest off until the bench asks
    always @(posedge clk_sys) eventIn <= wantIn;
endmodule

//--- tb/evh_event_handler_sva.sv
// Port-level checker for the event input handler
`timescale 1ns/1ps
module evh_event_handler_sva #(
    parameter int unsigned FILTER_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] eventIn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic programRun,
    input wire logic resetLamp,
    input wire logic remote_lamp,
    input wire logic keyWriteAllowed,
    input wire logic holdLamp,
    input wire logic stepPulse,
    input wire logic [2:0] patternNo
);
    int unsigned quietCnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Cycles since the raw inputs last moved; saturates so it never wraps
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            quietCnt <= 0;
        else
            quietCnt <= $changed(eventIn) ? 0 : (quietCnt < 1000 ? quietCnt + 1 : quietCnt);
    a_lamp_pair: assert property (resetLamp == !programRun)
        else $error("reset lamp disagrees with run state");
    a_key_remote: assert property (keyWriteAllowed == !remote_lamp)
        else $error("key writes allowed while remote");
    a_step_single: assert property (stepPulse |=> !stepPulse)
        else $error("step pulse longer than one cycle");
    a_step_running: assert property (stepPulse |-> $past(programRun))
        else $error("step advanced while reset");
    // Command-driven steps land with the write response, so those are excluded
    a_step_filtered: assert property (stepPulse && !s_axi_bvalid |-> quietCnt >= FILTER_CYCLES - 1)
        else $error("step taken before input settled");
    a_hold_running: assert property ($rose(holdLamp) |-> programRun)
        else $error("hold raised while reset");
    a_pattern_reset: assert property ($changed(patternNo) |-> !$past(programRun))
        else $error("pattern changed while running");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    cover property (stepPulse);
    cover property ($rose(remote_lamp));
    cover property ($changed(patternNo));
endmodule
bind evh_event_handler evh_event_handler_sva #(.FILTER_CYCLES(FILTER_CYCLES)) evh_event_handler_sva_inst (
    .clk_sys, .rst_n, .eventIn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .programRun, .resetLamp, .remote_lamp, .keyWriteAllowed,
    .holdLamp, .stepPulse, .patternNo);

//--- tb/tb_top.sv
// Self-checking bench for the event input handler
`timescale 1ns/1ps
`include "evh_params.svh"
module tb_top;
    localparam int unsigned FILT = 8;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] wantIn = 4'h0;
    logic [3:0] eventIn;
    logic [3:0] v;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic programRun, resetLamp, remote_lamp, hand_mode_lamp, holdLamp, stepPulse, keyWriteAllowed;
    logic [2:0] patternNo;
    int err_total = 0;
    int check_count = 0;
    initial forever #25 clk_sys = ~clk_sys;
    evh_contacts evh_contacts_inst (.clk_sys, .wantIn, .eventIn);
    evh_event_handler #(.FILTER_CYCLES(FILT)) evh_event_handler_inst (.clk_sys, .rst_n, .eventIn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .programRun, .resetLamp, .remote_lamp, .hand_mode_lamp,
        .holdLamp, .stepPulse, .patternNo, .keyWriteAllowed);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [2:0] patOf(input logic [15:0] asg, input logic [3:0] ev);
        patOf = 3'h0;
        for (int i = 0; i < 4; i++)
            if (ev[i] && asg[4*i+:4] >= 4'h6 && asg[4*i+:4] <= 4'h8)
                patOf = patOf | (3'h1 << (asg[4*i+:4] - 4'h6));
    endfunction
    // Ready is sampled at the falling edge, where nothing the bench drives can still move
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom);
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (!tb)
                s_axi_bready <= 1'b1;
        end
        while (!tb);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic axr(input logic [7:0] a);
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom);
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (ta)
                s_axi_arvalid <= 1'b0;
            if (!tr)
                s_axi_rready <= 1'b1;
        end
        while (!tr);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Holds the new contact levels well past the persistence time
    task automatic drive(input logic [3:0] lv);
        wantIn <= lv;
        repeat (FILT + 4) @(posedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        tally_and_finish;
    end
    initial
    begin
        void'($urandom(32'h00723b9d));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("resetOut", 32'h3, 32'({patternNo, programRun, resetLamp, keyWriteAllowed}));
        axr(`EVH_OFS_ASSIGN);
        chk("assignRst", `EVH_ASSIGN_RST, rd);
        axr(`EVH_OFS_OPTION);
        chk("optionRst", `EVH_OPTION_RST, rd);
        axr(8'h10);
        chk("unmapped", 32'(`EVH_RESP_SLVERR), 32'(rsp));
        axw(`EVH_OFS_ASSIGN, 32'h0000_0200);
        axr(`EVH_OFS_STATUS);
        chk("noSerial", 32'h1, 32'(rd[24]));
        axw(`EVH_OFS_OPTION, 32'h1);
        axw(`EVH_OFS_ASSIGN, 32'h0000_0002);
        axr(`EVH_OFS_STATUS);
        chk("remoteOne", 32'h1, 32'(rd[24]));
        axw(`EVH_OFS_ASSIGN, 32'h0000_4231);
        axr(`EVH_OFS_STATUS);
        chk("assignOk", 32'h0, 32'(rd[24]));
        drive(4'h1);
        drive(4'h0);
        chk("runOnFall", 32'h1, 32'(programRun));
        drive(4'h1);
        chk("resetOnRise", 32'h1, 32'({programRun, resetLamp}));
        drive(4'h0);
        wantIn <= 4'h2;
        repeat (FILT - 2) @(posedge clk_sys);
        drive(4'h0);
        chk("shortPulse", 32'h0, 32'(hand_mode_lamp));
        drive(4'h2);
        chk("manualIn", 32'h1, 32'(hand_mode_lamp));
        axw(`EVH_OFS_COMMAND, 32'h8020);
        chk("autoOverride", 32'h1, 32'(hand_mode_lamp));
        drive(4'h6);
        chk("remoteIn", 32'h2, 32'({remote_lamp, keyWriteAllowed}));
        axw(`EVH_OFS_COMMAND, 32'h0001);
        chk("keyLocked", 32'h1, 32'(programRun));
        axw(`EVH_OFS_COMMAND, 32'h8040);
        chk("holdOverride", 32'h0, 32'(holdLamp));
        drive(4'h8);
        chk("holdIn", 32'h4, 32'({holdLamp, hand_mode_lamp, remote_lamp}));
        drive(4'h0);
        chk("holdOff", 32'h0, 32'(holdLamp));
        axw(`EVH_OFS_COMMAND, 32'h0001);
        chk("keyReset", 32'h0, 32'(programRun));
        axw(`EVH_OFS_ASSIGN, 32'h0000_8765);
        for (int k = 0; k < 6; k++)
        begin
            v = 4'($urandom) & 4'he;
            drive(v);
            chk("pattern", 32'(patOf(16'h8765, v)), 32'(patternNo));
        end
        drive(4'he);
        chk("pattern7", 32'h7, 32'(patternNo));
        axw(`EVH_OFS_ASSIGN, 32'h0000_0070);
        drive(4'hf);
        chk("unassigned", 32'(patOf(16'h0070, 4'hf)), 32'(patternNo));
        axw(`EVH_OFS_ASSIGN, 32'h0000_8765);
        drive(4'h0);
        axw(`EVH_OFS_COMMAND, 32'h8002);
        drive(4'h6);
        chk("patternRun", 32'h0, 32'(patternNo));
        drive(4'h1);
        drive(4'h0);
        drive(4'h1);
        drive(4'h0);
        axr(`EVH_OFS_STATUS);
        chk("steps", 32'h2, 32'(rd[23:16]));
        axw(`EVH_OFS_ASSIGN, 32'h0000_0000);
        axw(`EVH_OFS_COMMAND, 32'h8104);
        axw(`EVH_OFS_COMMAND, 32'h0008);
        axr(`EVH_OFS_STATUS);
        chk("cmdSteps", 32'h3, 32'(rd[23:16]));
        chk("cmdRemote", 32'h1, 32'(remote_lamp));
        axw(`EVH_OFS_COMMAND, 32'h8048);
        chk("cmdLocalHold", 32'h1, 32'({remote_lamp, holdLamp}));
        axw(`EVH_OFS_COMMAND, 32'h8090);
        chk("cmdManual", 32'h1, 32'({holdLamp, hand_mode_lamp}));
        axw(`EVH_OFS_COMMAND, 32'h8001);
        axw(`EVH_OFS_COMMAND, 32'hd200);
        chk("cmdPattern", 32'h5, 32'(patternNo));
        axw(8'h10, 32'h0000_0000);
        chk("wrUnmapped", 32'(`EVH_RESP_SLVERR), 32'(rsp));
        tally_and_finish;
    end
endmodule
